/* pkg/tws_consts.vh */
// Constants for the two-wire unit status and bit-rate block
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
`define TWS_IDLE_CODE 5'h1F
`define TWS_STATE_LSB 3
`define TWS_STATE_W 5
`define TWS_FLAG_SET_POS 3
`define TWS_RATE_DIV0 16'h0080
`define TWS_RATE_DIV1 16'h0070
`define TWS_RATE_DIV2 16'h0060
`define TWS_RATE_DIV3 16'h0050
`define TWS_RATE_DIV4 16'h01E0
`define TWS_RATE_DIV5 16'h003C
`define TWS_RATE_DIV6 16'h001E
`define TWS_T1_MULT 16'h0030
`define TWS_T1_BASE 16'h0100
`define TWS_MC_CLKS_6 4'h6
`define TWS_MC_CLKS_12 4'hC
`endif

/* logic/tws_status_rate.v */
// Status-code register, serial flag control and master bit-rate divider
`timescale 1ns/10ps
// Contract
// - 8-bit status register is read only; writes do not change it.
// - Low three bits read zero; upper five hold the state code.
// - Twenty-six codes exist: one idle code, the rest defined states.
// - Code F8 means no information and requests no interrupt.
// - Entering any defined non-idle state sets the serial flag.
// - Valid code readable within one machine cycle of flag set.
// - Code held at least one machine cycle after flag clear.
// - 6-clock rates: 128,112,96,80,480,60,30 by rate select.
// - 12-clock rates double: 256,224,192,160,960,120,60.
// - 6-clock select 111 divides by 48 times (256 minus reload).
// - 12-clock select 111 divides by 96 times (256 minus reload).
// - Four modes: master transmit/receive, slave receive/transmit.
// - Frame: 7-bit address, direction bit, data bytes, each acked.
// - Transfer suspended while serial flag set until software clears.
// - Flag set holds clock line low; a high level is not affected.
// - Rate select affects master only; slaves follow external clock.
`include "tws_consts.vh"

module tws_status_rate #(
    parameter TWS_STATE_W = 5
) (
    input wire ref_clk_i, // Core clock, 200 MHz
    input wire rstn_i, // Asynchronous reset, active low
    input wire [4:0] state_code_i, // State code from the bus engine
    input wire state_enter_i, // Pulse: engine enters state_code_i
    input wire flag_clear_i, // Pulse: software clears the serial flag
    input wire flag_write_i, // Pulse: software writes the flag bit
    input wire flag_wdata_i, // Flag value written by software
    input wire status_wr_i, // Pulse: software writes status (ignored)
    input wire [7:0] status_wdata_i, // Ignored write data
    input wire twelve_clk_i, // High selects 12-clock core timing
    input wire rate_select_bit0_i, // Rate select bit 0
    input wire rate_select_bit1_i, // Rate select bit 1
    input wire rate_select_bit2_i, // Rate select bit 2
    input wire [7:0] t1_reload_i, // Timer 1 mode 2 reload value
    input wire master_i, // High while in a master mode
    input wire [1:0] mode_i, // 0 mtx,1 mrx,2 srx,3 stx
    input wire scl_line_i, // Clock line level from pin
    output reg [7:0] bus_state_code_o, // Status register read value
    output reg serial_flag_o, // Serial interrupt flag
    output wire transfer_hold_o, // High suspends the serial transfer
    output wire scl_o, // Clock line drive value (always low)
    output wire scl_oe_o, // High while pulling the clock line low
    output reg master_tick_o, // Pulse at each master half-bit point
    output reg [1:0] mode_o, // Current operating mode
    output reg scl_sync_o // Synchronised clock line for slaves
);

localparam [15:0] MAXDIV = 16'hFFFF;

reg rst_m_reg;
reg rst_s_reg;
wire rst_n;
reg [TWS_STATE_W-1:0] code_reg;
reg [TWS_STATE_W-1:0] code_next;
reg flag_reg;
reg flag_next;
reg [3:0] hold_cnt_reg;
reg [3:0] hold_cnt_next;
reg [TWS_STATE_W-1:0] pend_code_reg;
reg pend_reg;
reg [15:0] div_cnt_reg;
reg [15:0] divisor;
reg [15:0] base_div;
reg [15:0] t1_span;
reg [2:0] scl_sh_reg;
reg [31:0] t1_prod;
reg [15:0] div_half_reg;
reg stretch_reg;
wire [7:0] status_next;
wire [2:0] rate_sel;
reg [3:0] mc_clks;
genvar gi;

// Reset asserts at once but leaves on the clock, two stages deep, so no
// register sees the release close to an edge.
always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        rst_m_reg <= 1'b0;
        rst_s_reg <= 1'b0;
    end else begin
        rst_m_reg <= 1'b1;
        rst_s_reg <= rst_m_reg;
    end
end
assign rst_n = rst_s_reg;

// Rate select matters only while master_i is high.
assign rate_sel = {rate_select_bit2_i, rate_select_bit1_i,
    rate_select_bit0_i};

// Machine-cycle length in core clocks; it sizes the post-clear window.
always @* begin
    case (twelve_clk_i)
        1'b1: mc_clks = `TWS_MC_CLKS_12;
        default: mc_clks = `TWS_MC_CLKS_6;
    endcase
end

// Code update and flag set/clear. A code arriving while the previous one
// is still within its post-clear hold window is parked and applied when
// the window closes, so the old code stays readable a full machine cycle.
always @* begin
    code_next = code_reg;
    flag_next = flag_reg;
    hold_cnt_next = (hold_cnt_reg != 4'h0) ? hold_cnt_reg - 4'h1 : 4'h0;
    if (flag_clear_i || (flag_write_i && !flag_wdata_i)) begin
        flag_next = 1'b0;
        hold_cnt_next = mc_clks;
    end
    if (state_enter_i && hold_cnt_reg == 4'h0 && !pend_reg) begin
        code_next = state_code_i;
        if (state_code_i != `TWS_IDLE_CODE) begin
            flag_next = 1'b1;
        end
    end else if (pend_reg && hold_cnt_reg == 4'h0) begin
        // Parked code lands as the window closes; a same-cycle clear
        // loses to this set so the event is never dropped.
        code_next = pend_code_reg;
        if (pend_code_reg != `TWS_IDLE_CODE) begin
            flag_next = 1'b1;
        end
    end
end

always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        code_reg <= `TWS_IDLE_CODE;
        flag_reg <= 1'b0;
        hold_cnt_reg <= 4'h0;
    end else begin
        code_reg <= code_next;
        flag_reg <= flag_next;
        hold_cnt_reg <= hold_cnt_next;
    end
end

// park during window
// A code arriving inside the hold window is parked here; a later one
// overwrites it, so software sees only the newest state after the window.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        pend_reg <= 1'b0;
        pend_code_reg <= `TWS_IDLE_CODE;
    end else begin
        if (state_enter_i && (hold_cnt_reg != 4'h0 || pend_reg)) begin
            pend_reg <= 1'b1;
            pend_code_reg <= state_code_i;
        end else if (hold_cnt_reg == 4'h0) begin
            pend_reg <= 1'b0;
        end
    end
end

// five-bit code space
// Low bits are tied off per bit; the code fills the rest.
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat_bit
        if (gi < `TWS_STATE_LSB) begin : g_low
            assign status_next[gi] = 1'b0;
        end else begin : g_code
            assign status_next[gi] = code_next[gi - `TWS_STATE_LSB];
        end
    end
endgenerate

// writes ignored
// Only the engine's code reaches the register; the write strobe and
// its data go nowhere, so a write can never disturb a held code.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        bus_state_code_o <= {`TWS_IDLE_CODE, 3'h0};
    end else begin
        bus_state_code_o <= status_next;
    end
end

// flag output
// Registered from the same next value as the internal flag so the two
// never disagree by a cycle.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        serial_flag_o <= 1'b0;
    end else begin
        serial_flag_o <= flag_next;
    end
end

// suspend while flagged
// The engine freezes its shift and bit timing while this is high.
assign transfer_hold_o = flag_reg;

// stretch low only
// The pull starts only once the synchronised line reads low, so a high
// level is never forced down and no loop forms through the pin.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        stretch_reg <= 1'b0;
    end else begin
        stretch_reg <= flag_next & (stretch_reg | ~scl_sync_o);
    end
end
// Drive value is fixed low; only the enable moves, as on an open drain.
assign scl_o = 1'b0;
assign scl_oe_o = stretch_reg;

always @* begin
    case (rate_sel)
        3'h0: base_div = `TWS_RATE_DIV0;
        3'h1: base_div = `TWS_RATE_DIV1;
        3'h2: base_div = `TWS_RATE_DIV2;
        3'h3: base_div = `TWS_RATE_DIV3;
        3'h4: base_div = `TWS_RATE_DIV4;
        3'h5: base_div = `TWS_RATE_DIV5;
        3'h6: base_div = `TWS_RATE_DIV6;
        default: base_div = `TWS_RATE_DIV0;
    endcase
    // timer 1 span
    // The span is one to 256 counts, so the product fits in 16 bits.
    t1_span = `TWS_T1_BASE - {8'h00, t1_reload_i};
    t1_prod = `TWS_T1_MULT * t1_span;
    if (rate_sel == 3'h7) begin
        divisor = t1_prod[15:0];
    end else begin
        divisor = base_div;
    end
    if (twelve_clk_i) begin
        divisor = {divisor[14:0], 1'b0};
    end
    // A zero divisor cannot occur with an 8-bit reload; the guard keeps
    // the half-period bound from wrapping if the constants ever change.
    if (divisor == 16'h0000) begin
        divisor = MAXDIV;
    end
end

// Divisor pipeline: the product and the halving settle in one stage so
// the compare below sees a registered bound. A rate change takes effect
// one clock later.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        div_half_reg <= 16'h0000;
    end else begin
        div_half_reg <= {1'b0, divisor[15:1]} - 16'h0001;
    end
end

// Tick splits the bit period in halves so the engine can time high and
// low phases; odd divisors lose one clock in rounding.
// master only divider
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        div_cnt_reg <= 16'h0000;
        master_tick_o <= 1'b0;
    end else if (!master_i || flag_reg) begin
        div_cnt_reg <= 16'h0000;
        master_tick_o <= 1'b0;
    end else if (div_cnt_reg >= div_half_reg) begin
        div_cnt_reg <= 16'h0000;
        master_tick_o <= 1'b1;
    end else begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
        master_tick_o <= 1'b0;
    end
end

// slave clock sync
// Three stages on the pin; a level counts once the last two agree, so a
// single-clock glitch never reaches the engine.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        scl_sh_reg <= 3'h7;
        scl_sync_o <= 1'b1;
    end else begin
        scl_sh_reg <= {scl_sh_reg[1:0], scl_line_i};
        if (scl_sh_reg[1] == scl_sh_reg[2]) begin
            scl_sync_o <= scl_sh_reg[2];
        end
    end
end

// four modes
// Registered so the mode code moves on the same edge as the status.
always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        mode_o <= 2'h0;
    end else begin
        mode_o <= mode_i;
    end
end

// framing in engine
// status_wr_i and status_wdata_i are accepted and dropped on purpose.
endmodule // tws_status_rate

/* verification/tws_status_rate_props.sv */
// Port assertions for the status and bit-rate block
`timescale 1ns/10ps
module tws_status_rate_props (
    input wire ref_clk_i, // Core clock
    input wire rstn_i, // Reset, active low
    input wire state_enter_i, // State entry pulse
    input wire [4:0] state_code_i, // Entered code
    input wire status_wr_i, // Status write pulse
    input wire master_i, // Master mode
    input wire scl_line_i, // Clock line level
    input wire [7:0] bus_state_code_o, // Status value
    input wire serial_flag_o, // Serial flag
    input wire transfer_hold_o, // Transfer hold
    input wire scl_o, // Clock drive value
    input wire scl_oe_o, // Clock pull enable
    input wire master_tick_o, // Master tick
    input wire scl_sync_o // Synchronised clock line
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence code_kept;
        $stable(bus_state_code_o)[*6];
    endsequence
    low_bits_zero_a: assert property (bus_state_code_o[2:0] == 3'h0)
        else $error("status low bits not zero");
    idle_no_flag_a: assert property ($rose(serial_flag_o) |->
        bus_state_code_o != 8'hF8) else $error("flag with idle code");
    flag_on_entry_a: assert property (state_enter_i &&
        state_code_i != 5'h1F |=> ##[0:13] serial_flag_o)
        else $error("entry did not set flag");
    code_with_flag_a: assert property ($rose(serial_flag_o) &&
        $past(state_enter_i) |-> bus_state_code_o[7:3] ==
        $past(state_code_i)) else $error("code late after flag");
    code_held_a: assert property ($fell(serial_flag_o) |->
        code_kept) else $error("code changed after clear");
    write_ignored_a: assert property (status_wr_i &&
        !state_enter_i && serial_flag_o |=> $stable(bus_state_code_o))
        else $error("status write took effect");
    hold_follows_a: assert property (transfer_hold_o ==
        serial_flag_o) else $error("hold differs from flag");
    clock_stretch_a: assert property (scl_o == 1'b0 &&
        (!scl_oe_o || serial_flag_o)) else $error("bad clock stretch");
    stretch_start_a: assert property (serial_flag_o &&
        !scl_sync_o |=> scl_oe_o == serial_flag_o)
        else $error("low line not stretched");
    high_untouched_a: assert property (!scl_oe_o &&
        scl_sync_o |=> !scl_oe_o) else $error("high line pulled low");
    tick_master_a: assert property (master_tick_o |->
        $past(master_i) && !$past(serial_flag_o)) else $error("bad tick");
endmodule // tws_status_rate_props
bind tws_status_rate tws_status_rate_props chk_u (.ref_clk_i, .rstn_i,
    .state_enter_i, .state_code_i, .status_wr_i, .master_i, .scl_line_i,
    .bus_state_code_o, .serial_flag_o, .transfer_hold_o, .scl_o,
    .scl_oe_o, .master_tick_o, .scl_sync_o);

/* verification/tws_bus_peer.sv */
// Clock line with pull-up shared with another bus party
`timescale 1ns/10ps
module tws_bus_peer (
    input wire scl_oe_i, // Block pulls the line
    input wire scl_i, // Block drive value
    input wire pull_i, // Other party holds the line low
    output wire line_o // Resolved line level
);
    assign line_o = !((scl_oe_i && !scl_i) || pull_i);
endmodule // tws_bus_peer

/* verification/tws_status_rate_tb.sv */
// Self-checking bench for the status and bit-rate block
`timescale 1ns/10ps
module tws_status_rate_tb;
    reg clk = 0, rstn = 0, enter = 0, clr = 0, fw = 0, wr = 0, tw = 0;
    reg pull = 0;
    reg [4:0] code = 0;
    reg [2:0] sel = 0;
    reg [1:0] mi = 0;
    wire [7:0] st;
    wire [1:0] mo;
    wire fl, hold, so, soe, tick, sync, line;
    int n_mismatch = 0, num_checks = 0, i, p;
    typedef struct {bit t; bit [2:0] s; int per;} row_t;
    row_t rows[16] = '{'{0,0,64}, '{0,1,56}, '{0,2,48}, '{0,3,40},
        '{0,4,240}, '{0,5,30}, '{0,6,15}, '{0,7,48}, '{1,0,128},
        '{1,1,112}, '{1,2,96}, '{1,3,80}, '{1,4,480}, '{1,5,60},
        '{1,6,30}, '{1,7,96}};
    always #2.5 clk = ~clk;
    tws_bus_peer peer_u (.scl_oe_i(soe), .scl_i(so), .pull_i(pull),
        .line_o(line));
    tws_status_rate dut_u (.ref_clk_i(clk), .rstn_i(rstn),
        .state_code_i(code), .state_enter_i(enter), .flag_clear_i(clr),
        .flag_write_i(fw), .flag_wdata_i(1'b0), .status_wr_i(wr),
        .status_wdata_i(8'hFF), .twelve_clk_i(tw),
        .rate_select_bit0_i(sel[0]), .rate_select_bit1_i(sel[1]),
        .rate_select_bit2_i(sel[2]), .t1_reload_i(8'hFE),
        .master_i(1'b1), .mode_i(mi), .scl_line_i(line),
        .bus_state_code_o(st), .serial_flag_o(fl), .transfer_hold_o(hold),
        .scl_o(so), .scl_oe_o(soe), .master_tick_o(tick), .mode_o(mo),
        .scl_sync_o(sync));
    task chk(input bit c, input string s);
        num_checks++;
        if (!c) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Counts cycles up to the next tick, bounded
    task gap(output int n);
        n = 1;
        @(negedge clk);
        while (tick !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            chk(0, "tick timeout");
            final_report;
        end
    endtask
    task step;
        @(negedge clk);
        {enter, wr, clr, fw} = 4'h0;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1;
        repeat (3) @(negedge clk);
        chk(st === 8'hF8 && fl === 1'b0 && sync === 1'b1, "reset");
        for (i = 1; i < 26; i++) begin
            code = i[4:0];
            enter = 1;
            step;
            chk(st === {code, 3'h0} && fl === 1'b1, "set");
            wr = 1;
            step;
            chk(st === {code, 3'h0} && soe === 1'b0, "ro");
            pull = 1;
            repeat (6) @(negedge clk);
            pull = 0;
            step;
            chk(soe === 1'b1 && line === 1'b0, "stretch");
            if (i[0]) clr = 1;
            else fw = 1;
            step;
            chk(fl === 1'b0 && hold === 1'b0, "clear");
            repeat (13) @(negedge clk);
        end
        code = 5'h02;
        enter = 1;
        step;
        clr = 1;
        step;
        code = 5'h03;
        enter = 1;
        step;
        repeat (3) @(negedge clk);
        chk(st === 8'h10 && fl === 1'b0, "held");
        repeat (6) @(negedge clk);
        chk(st === 8'h18 && fl === 1'b1, "parked");
        clr = 1;
        step;
        repeat (13) @(negedge clk);
        code = 5'h1F;
        enter = 1;
        step;
        chk(st === 8'hF8 && fl === 1'b0, "idle");
        pull = 1;
        repeat (4) @(negedge clk);
        chk(sync === 1'b0, "slave sync");
        pull = 0;
        for (i = 0; i < 16; i++) begin
            tw = rows[i].t;
            sel = rows[i].s;
            mi = i[1:0];
            gap(p);
            gap(p);
            chk(p == rows[i].per, "rate");
            chk(mo === mi, "mode");
        end
        final_report;
    end
endmodule // tws_status_rate_tb
